// File: thpd_pkg.sv
// package of constants for the tag head cyclic and command port
// Behaviour
// R01: pretransmit code: begin,finish,single,multiple,delete,stop
// R02: controller fills subindex fully, states count
// R03: unassigned cyclic input bytes read zero
// R04: direct write stored only on payload subindex
// R05: cyclic image six words each direction
// R06: status byte 0 low nibble: result code
// R07: event counter increments at pre-link end, wraps
// R08: counter changes only after pretransmit/prefetch done
// R09: status byte 1 bit 0: operative flag
// R10: bit 1: any prefetch parameterized
// R11: bit 2: prefetch parameterization open
// R12: bit 3: open/close transfer status
// R13: status byte 1 high nibble: actual link state
// R14: prefetch data from third byte, else zero
// R15: trigger toggle applies commanded link nibble
// R16: ignore bits 4-6 and other output bytes
// R17: trigger and nibble sampled together
// R18: trigger not echoed in input image
// R19: controller inverts trigger per new command
// R20: direct address 4 bytes, count 2 bytes; the port keeps only the low count byte (dw_count is 8 bits)
// R21: reset captures trigger level without executing
package thpd_pkg;
    // ------------------------------------------------------------
    // cyclic image geometry
    // ------------------------------------------------------------
    localparam int IMG_WORDS     = 6;               // words per direction
    localparam int IMG_BYTES     = 2 * IMG_WORDS;   // bytes per direction
    localparam int IMG_BITS      = 8 * IMG_BYTES;   // 96 bits
    localparam int PF_BYTES      = IMG_BYTES - 2;   // prefetch bytes
    localparam int TRIG_BIT      = 7;               // trigger in output byte 0
    localparam int NIB_LO        = 0;               // commanded nibble lsb
    localparam int NIB_HI        = 3;               // commanded nibble msb
    // ------------------------------------------------------------
    // status byte 1 bit positions
    // ------------------------------------------------------------
    localparam int ST1_OPER      = 0;
    localparam int ST1_PF_PARAM  = 1;
    localparam int ST1_PF_OPEN   = 2;
    localparam int ST1_XFER      = 3;
    // ------------------------------------------------------------
    // pretransmit configuration codes (16 bit)
    // ------------------------------------------------------------
    localparam logic [15:0] PT_BEGIN  = 16'h0000;
    localparam logic [15:0] PT_FINISH = 16'h0001;
    localparam logic [15:0] PT_SINGLE = 16'h0002;
    localparam logic [15:0] PT_MULTI  = 16'h0003;
    localparam logic [15:0] PT_DELETE = 16'h0004;
    localparam logic [15:0] PT_STOP   = 16'h0005;
    // ------------------------------------------------------------
    // direct access subindexes
    // ------------------------------------------------------------
    localparam logic [7:0] SUB_ADDR    = 8'h01;
    localparam logic [7:0] SUB_COUNT   = 8'h02;
    localparam logic [7:0] SUB_PAYLOAD = 8'h03;
    localparam logic [3:0] NIB_ZERO    = 4'h0;
    localparam logic [7:0] BYTE_ZERO   = 8'h00;
    // pretransmit engine modes
    typedef enum logic [2:0] {
        THPD_PT_IDLE, THPD_PT_PARAM, THPD_PT_SINGLE, THPD_PT_MULTI
    } thpd_pt_mode_t;
endpackage : thpd_pkg

// File: thpd_trigger.sv
// trigger edge detector for the commanded link state byte
`timescale 1ns/1ps
module thpd_trigger (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    // output byte 0 as received
    input  wire logic [7:0] out_byte0,
    input  wire logic       out_valid,
    // applied command
    output logic            cmd_pulse,
    output logic [3:0]      cmd_state
);
    logic trig_ref;   // last trigger level seen
    logic armed;      // reference taken after reset

    // ------------------------------------------------------------
    // edge detect on whole byte snapshot
    // ------------------------------------------------------------
    // nibble and trigger come from the same byte sample
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            trig_ref  <= 1'b0;
            armed     <= 1'b0;
            cmd_pulse <= 1'b0;
            cmd_state <= thpd_pkg::NIB_ZERO;
        end else begin
            cmd_pulse <= 1'b0;
            if (out_valid) begin
                trig_ref <= out_byte0[thpd_pkg::TRIG_BIT];
                armed    <= 1'b1;   // R21
                // either edge applies the nibble
                if (armed && (out_byte0[thpd_pkg::TRIG_BIT] != trig_ref)) begin  // R15
                    cmd_pulse <= 1'b1;
                    cmd_state <= out_byte0[thpd_pkg::NIB_HI:thpd_pkg::NIB_LO];  // R17
                end
            end
        end
    end
endmodule : thpd_trigger

// File: thpd_port.sv
// top of the tag head cyclic image and acyclic parameter channel port
`timescale 1ns/1ps
module thpd_port #(
    parameter int PF_BYTES = thpd_pkg::PF_BYTES
) (
    // clock and reset
    input  wire logic                        ref_clk,
    input  wire logic                        rstn,
    // cyclic image from controller
    input  wire logic [thpd_pkg::IMG_BITS-1:0] cyc_out_image,
    input  wire logic                        cyc_out_valid,
    // cyclic image to controller
    output logic [thpd_pkg::IMG_BITS-1:0]    cyc_in_image,
    // head status from the engines
    input  wire logic [3:0]                  result_code,
    input  wire logic [3:0]                  actual_link_state,
    input  wire logic                        operative_flag,
    input  wire logic                        pre_link_end,
    input  wire logic                        pretransmit_done,
    input  wire logic                        prefetch_ready,
    input  wire logic                        link_settled,
    input  wire logic                        pf_parameterized,
    input  wire logic                        pf_param_open,
    input  wire logic                        open_transfer_cmd,
    input  wire logic                        close_transfer_cmd,
    input  wire logic                        pf_valid,
    input  wire logic [8*PF_BYTES-1:0]       pf_data,
    // acyclic parameter channel writes
    input  wire logic                        acy_valid,
    input  wire logic                        acy_is_direct,
    input  wire logic [7:0]                  acy_subindex,
    input  wire logic [31:0]                 acy_data,
    // commanded link state to the link engine
    output logic                             link_cmd_pulse,
    output logic [3:0]                       link_cmd_state,
    // pretransmit configuration
    output logic                             pt_cmd_pulse,
    output logic [2:0]                       pt_cmd_code,
    // direct write to data tag
    output logic                             dw_pulse,
    output logic [31:0]                      dw_addr,
    output logic [7:0]                       dw_count
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [3:0]  event_count;   // wraps 15 to 0
    logic        xfer_status;   // open/close transfer
    logic        end_pending;   // pre-link end awaiting completion
    logic [8*PF_BYTES-1:0] pf_hold; // latched prefetch bytes
    logic        cmd_p;         // from trigger detector
    logic [3:0]  cmd_s;

    // ------------------------------------------------------------
    // trigger detector
    // ------------------------------------------------------------
    thpd_trigger u_trig (
        .ref_clk   (ref_clk),
        .rstn      (rstn),
        .out_byte0 (cyc_out_image[7:0]),   // R16
        .out_valid (cyc_out_valid),
        .cmd_pulse (cmd_p),
        .cmd_state (cmd_s)
    );

    // registered command outputs
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            link_cmd_pulse <= 1'b0;
            link_cmd_state <= thpd_pkg::NIB_ZERO;
        end else begin
            link_cmd_pulse <= cmd_p;   // R15
            if (cmd_p)
                link_cmd_state <= cmd_s;
        end
    end

    // ------------------------------------------------------------
    // event counter
    // ------------------------------------------------------------
    // counts after all steps complete; pre-link ends arriving while one is pending add only one count
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            event_count <= thpd_pkg::NIB_ZERO;
            end_pending <= 1'b0;
        end else begin
            if (end_pending && pretransmit_done && prefetch_ready && link_settled) begin  // R08
                event_count <= event_count + 4'h1;   // R07
                end_pending <= pre_link_end;
            end else if (pre_link_end) begin
                end_pending <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // transfer status flag
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            xfer_status <= 1'b0;
        end else if (open_transfer_cmd) begin
            xfer_status <= 1'b1;   // R12
        end else if (close_transfer_cmd) begin
            xfer_status <= 1'b0;   // R12
        end
    end

    // ------------------------------------------------------------
    // prefetch data hold
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pf_hold <= '0;   // R14
        end else if (pf_valid) begin
            pf_hold <= pf_data;
        end
    end

    // ------------------------------------------------------------
    // input image build
    // ------------------------------------------------------------
    // trigger is never echoed; unused bytes stay zero
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            cyc_in_image <= '0;   // R03
        end else begin
            cyc_in_image <= '0;   // R03 R05 R18
            cyc_in_image[3:0] <= result_code;   // R06
            cyc_in_image[7:4] <= event_count;   // R07
            cyc_in_image[8 + thpd_pkg::ST1_OPER]     <= operative_flag;    // R09
            cyc_in_image[8 + thpd_pkg::ST1_PF_PARAM] <= pf_parameterized;  // R10
            cyc_in_image[8 + thpd_pkg::ST1_PF_OPEN]  <= pf_param_open;     // R11
            cyc_in_image[8 + thpd_pkg::ST1_XFER]     <= xfer_status;       // R12
            cyc_in_image[15:12] <= actual_link_state;   // R13
            cyc_in_image[16 +: 8*PF_BYTES] <= pf_hold;  // R14
        end
    end

    // ------------------------------------------------------------
    // pretransmit configuration decode
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            pt_cmd_pulse <= 1'b0;
            pt_cmd_code  <= 3'h0;
        end else begin
            pt_cmd_pulse <= 1'b0;
            if (acy_valid && !acy_is_direct) begin
                // only codes 0 to 5 are accepted
                case (acy_data[15:0])   // R01
                    thpd_pkg::PT_BEGIN, thpd_pkg::PT_FINISH, thpd_pkg::PT_SINGLE,
                    thpd_pkg::PT_MULTI, thpd_pkg::PT_DELETE, thpd_pkg::PT_STOP: begin
                        pt_cmd_pulse <= 1'b1;
                        pt_cmd_code  <= acy_data[2:0];
                    end
                    default: pt_cmd_pulse <= 1'b0;
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // direct write sequencing
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            dw_pulse <= 1'b0;
            dw_addr  <= 32'h00000000;
            dw_count <= thpd_pkg::BYTE_ZERO;
        end else begin
            dw_pulse <= 1'b0;
            if (acy_valid && acy_is_direct) begin
                case (acy_subindex)
                    thpd_pkg::SUB_ADDR:    dw_addr  <= acy_data;          // R20
                    thpd_pkg::SUB_COUNT:   dw_count <= acy_data[7:0];     // R20 R02
                    thpd_pkg::SUB_PAYLOAD: dw_pulse <= 1'b1;              // R04
                    default:               dw_pulse <= 1'b0;
                endcase
            end
        end
    end
endmodule : thpd_port

// File: thpd_port_monitor.sv
// checker of the port outputs against their causes
`timescale 1ns/1ps
module thpd_port_monitor (
    // clock and reset
    input wire logic                          ref_clk,
    input wire logic                          rstn,
    // cyclic images
    input wire logic [thpd_pkg::IMG_BITS-1:0] cyc_out_image,
    input wire logic                          cyc_out_valid,
    input wire logic [thpd_pkg::IMG_BITS-1:0] cyc_in_image,
    // head status
    input wire logic [3:0]                    result_code,
    input wire logic [3:0]                    actual_link_state,
    // acyclic channel
    input wire logic                          acy_valid,
    input wire logic                          acy_is_direct,
    input wire logic [7:0]                    acy_subindex,
    input wire logic [31:0]                   acy_data,
    // commands out
    input wire logic                          link_cmd_pulse,
    input wire logic [3:0]                    link_cmd_state,
    input wire logic                          pt_cmd_pulse,
    input wire logic [2:0]                    pt_cmd_code,
    input wire logic                          dw_pulse
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    logic armed;    // first valid sample after reset seen
    logic trig_ref; // trigger level of the last valid sample
    // track the trigger reference as the head should
    always_ff @(posedge ref_clk) begin
        if (!rstn) begin
            armed    <= 1'b0;
            trig_ref <= 1'b0;
        end else if (cyc_out_valid) begin
            armed    <= 1'b1;
            trig_ref <= cyc_out_image[7];
        end
    end
    wire tog = cyc_out_valid && armed && (cyc_out_image[7] != trig_ref); // toggled sample
    wire pt_ok = acy_valid && !acy_is_direct && (acy_data[15:0] <= 16'h0005);
    wire dw_go = acy_valid && acy_is_direct && (acy_subindex == 8'h03);
    a_result_copy: assert property ($past(rstn) |-> cyc_in_image[3:0] == $past(result_code))
        else $error("result code not copied");
    a_link_copy: assert property (
        $past(rstn) |-> cyc_in_image[15:12] == $past(actual_link_state))
        else $error("link state not copied");
    a_pt_apply: assert property (
        pt_ok |=> pt_cmd_pulse && pt_cmd_code == $past(acy_data[2:0]))
        else $error("pretransmit code not applied");
    a_pt_refuse: assert property (!pt_ok |=> !pt_cmd_pulse)
        else $error("pretransmit pulse without valid code");
    a_dw_payload: assert property (dw_go |=> dw_pulse)
        else $error("payload did not store");
    a_dw_hold: assert property (!dw_go |=> !dw_pulse)
        else $error("store without payload");
    a_trig_apply: assert property (
        tog |-> ##2 link_cmd_pulse && link_cmd_state == $past(cyc_out_image[3:0], 2))
        else $error("trigger toggle not applied");
    a_trig_quiet: assert property (!tog |-> ##2 !link_cmd_pulse)
        else $error("link command without toggle");
    a_count_step: assert property (
        $past(rstn) && $changed(cyc_in_image[7:4])
        |-> cyc_in_image[7:4] == $past(cyc_in_image[7:4]) + 4'h1)
        else $error("event counter step wrong");
endmodule : thpd_port_monitor
bind thpd_port thpd_port_monitor i_thpd_port_monitor (.ref_clk(ref_clk), .rstn(rstn),
    .cyc_out_image(cyc_out_image), .cyc_out_valid(cyc_out_valid), .cyc_in_image(cyc_in_image),
    .result_code(result_code), .actual_link_state(actual_link_state), .acy_valid(acy_valid),
    .acy_is_direct(acy_is_direct), .acy_subindex(acy_subindex), .acy_data(acy_data),
    .link_cmd_pulse(link_cmd_pulse), .link_cmd_state(link_cmd_state),
    .pt_cmd_pulse(pt_cmd_pulse), .pt_cmd_code(pt_cmd_code), .dw_pulse(dw_pulse));

// File: thpd_ctrl_model.sv
// controller model driving the cyclic output image
`timescale 1ns/1ps
module thpd_ctrl_model (
    // clock
    input  wire logic        ref_clk,
    // commands from the bench
    input  wire logic        run,
    input  wire logic        go,
    input  wire logic [3:0]  nib,
    input  wire logic [95:0] noise,
    // cyclic output image
    output logic [95:0]      image = 96'h0,
    output logic             valid = 1'b0
);
    logic        trig = 1'b1; // starts high so arming after reset matters
    logic        g;           // command taken at the edge
    logic [95:0] n;           // noise taken at the edge
    // image changes just after each edge; ignored bits carry noise
    always @(posedge ref_clk) begin
        g = go;
        n = noise;
        #1;
        valid = run;
        if (g) trig = ~trig;
        image = {n[95:8], trig, n[6:4], g ? nib : n[3:0]};
    end
endmodule : thpd_ctrl_model

// File: thpd_port_tb_top.sv
// self-checking bench for the tag head cyclic and command port
`timescale 1ns/1ps
module thpd_port_tb_top;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    logic run, go, oper, ple, ptd, pfr, lks, pfp, pfo, opn, cls, pfv, av, ad, lcp, ptp, dwp;
    logic [95:0] img_o, img_i, noise, pfx;
    logic [79:0] pfd;
    logic [31:0] rs = 32'h1D, r, adata, dwa, a;
    logic [7:0]  asub, dwc;
    logic [3:0]  rc, ls, nib, lcs;
    logic [2:0]  ptc;
    logic        vo;
    int failures = 0;
    int n_checks = 0;
    int cyc = 0;
    int cnt = 0; // expected event counter
    always #20 ref_clk = ~ref_clk;
    thpd_ctrl_model i_thpd_ctrl_model (.ref_clk(ref_clk), .run(run), .go(go), .nib(nib),
        .noise(noise), .image(img_o), .valid(vo));
    thpd_port i_thpd_port (.ref_clk(ref_clk), .rstn(rstn), .cyc_out_image(img_o),
        .cyc_out_valid(vo), .cyc_in_image(img_i), .result_code(rc), .actual_link_state(ls),
        .operative_flag(oper), .pre_link_end(ple), .pretransmit_done(ptd), .prefetch_ready(pfr),
        .link_settled(lks), .pf_parameterized(pfp), .pf_param_open(pfo), .open_transfer_cmd(opn),
        .close_transfer_cmd(cls), .pf_valid(pfv), .pf_data(pfd), .acy_valid(av),
        .acy_is_direct(ad), .acy_subindex(asub), .acy_data(adata), .link_cmd_pulse(lcp),
        .link_cmd_state(lcs), .pt_cmd_pulse(ptp), .pt_cmd_code(ptc), .dw_pulse(dwp),
        .dw_addr(dwa), .dw_count(dwc));
    function automatic logic [31:0] rnd();
        rs = rs ^ (rs << 13);
        rs = rs ^ (rs >> 17);
        rs = rs ^ (rs << 5);
        return rs;
    endfunction : rnd
    task automatic step(input int k);
        repeat (k) @(posedge ref_clk);
        #1;
    endtask : step
    task automatic chk(input logic [95:0] got, input logic [95:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk
    task automatic summarize();
        if (failures == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : summarize
    // cut a hang short
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 3000) begin
            failures++;
            summarize();
        end
    end
    initial begin
        {run, go, oper, ple, ptd, pfr, lks, pfp, pfo, opn, cls, pfv, av, ad} = 14'h0;
        {noise, pfd, adata, asub, rc, ls, nib} = '0;
        step(4);
        rstn = 1'b1;
        run = 1'b1;
        // status bytes follow the head, prefetch area reads zero, no command yet
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            {rc, ls, oper, pfp, pfo} = r[10:0];
            noise = {rnd(), rnd(), rnd()};
            step(1);
            pfx = {80'h0, ls, 1'b0, pfo, pfp, oper, cnt[3:0], rc};
            chk(img_i, pfx, "status");
            chk({lcp, ptp, dwp}, 96'h0, "quiet");
        end
        // transfer status set by open, cleared by close
        opn = 1'b1;
        step(1);
        opn = 1'b0;
        step(1);
        chk(img_i[11], 1'b1, "xfer open");
        cls = 1'b1;
        step(1);
        cls = 1'b0;
        step(1);
        chk(img_i[11], 1'b0, "xfer close");
        // prefetch bytes load and hold
        pfd = 80'({rnd(), rnd(), rnd()});
        pfx = {pfd, 16'h0};
        pfv = 1'b1;
        step(1);
        pfv = 1'b0;
        pfd = ~pfd;
        step(2);
        chk(img_i[95:16], pfx[95:16], "prefetch");
        // event counter counts only once all steps are done, and wraps
        // every third end holds one done level low in turn
        for (int i = 0; i < 18; i++) begin
            {ptd, pfr, lks} = (i % 3 == 0) ? ~(3'b001 << ((i / 3) % 3)) : 3'b111;
            ple = 1'b1;
            step(1);
            ple = 1'b0;
            step(4);
            if (i % 3 == 0) begin
                chk(img_i[7:4], cnt[3:0], "count early");
                {ptd, pfr, lks} = 3'b111;
                step(4);
            end
            cnt++;
            chk(img_i[7:4], cnt[3:0], "count");
        end
        // every pretransmit code, then one out of range
        for (int c = 0; c < 7; c++) begin
            {av, ad, adata} = {2'b10, 32'(c)};
            step(1);
            chk(ptp, c < 6, "pt pulse");
            if (c < 6) chk(ptc, c[2:0], "pt code");
            av = 1'b0;
            step(1);
        end
        // direct write: address, count, bad subindex, then payload
        a = rnd();
        r = rnd();
        for (int s = 1; s < 5; s++) begin
            {av, ad} = 2'b11;
            asub = (s == 3) ? 8'h04 : (s == 4) ? 8'h03 : 8'(s);
            adata = (s == 1) ? a : (s == 2) ? {24'h0, r[7:0]} : rnd();
            step(1);
            chk(dwp, s == 4, "store pulse");
            av = 1'b0;
            step(1);
        end
        chk({dwa, dwc}, {a, r[7:0]}, "store target");
        // link commands through trigger toggles
        for (int i = 0; i < 6; i++) begin
            r = rnd();
            nib = r[3:0];
            noise = {rnd(), rnd(), rnd()};
            go = 1'b1;
            step(1);
            go = 1'b0;
            step(1);
            chk(lcp, 1'b0, "early link cmd");
            step(1);
            chk({lcp, lcs}, {1'b1, nib}, "link cmd");
        end
        summarize();
    end
endmodule : thpd_port_tb_top
